// File: asr_pkg.sv
// constants for the shadow register block
package asr_pkg;
    // register select codes on the host access port
    localparam logic [3:0] SEL_DATA = 4'h0;
    localparam logic [3:0] SEL_ERR_FEAT = 4'h1;
    localparam logic [3:0] SEL_COUNT = 4'h2;
    localparam logic [3:0] SEL_ADDR_LOW = 4'h3;
    localparam logic [3:0] SEL_ADDR_MID = 4'h4;
    localparam logic [3:0] SEL_ADDR_HIGH = 4'h5;
    localparam logic [3:0] SEL_DRIVE_HEAD = 4'h6;
    localparam logic [3:0] SEL_STATUS_CMD = 4'h7;
    localparam logic [3:0] SEL_CONTROL = 4'he;
    // device control fields
    localparam int CTL_READBACK_BIT = 7;
    localparam int CTL_SOFT_RESET_BIT = 2;
    localparam int CTL_IRQ_MASK_BIT = 1;
    // drive/head fields
    localparam int DH_LBA_MODE_BIT = 6;
    localparam int DH_DRIVE_SELECT_BIT = 4;
    // status fields
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_FAULT = 5;
    localparam int ST_SEEK_DONE = 4;
    localparam int ST_XFER_REQ = 3;
    localparam int ST_CORRECTED = 2;
    localparam int ST_INDEX = 1;
    localparam int ST_ERR = 0;
    // error fields
    localparam int ER_LINK_CRC = 7;
    localparam int ER_UNCORR = 6;
    localparam int ER_ZERO5 = 5;
    localparam int ER_ID_MISS = 4;
    localparam int ER_ZERO3 = 3;
    localparam int ER_ABORTED = 2;
    localparam int ER_TRACK0 = 1;
    localparam int ER_MARK_MISS = 0;
    // reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_DRIVE_HEAD = 8'ha0;
    localparam logic [7:0] RST_COUNT = 8'h01;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // sector counts implied by a zero count
    localparam logic [16:0] ZERO_COUNT_28 = 17'h00100;
    localparam logic [16:0] ZERO_COUNT_48 = 17'h10000;
    // ready delay after reset
    localparam int READY_DELAY_NS = 400;
    localparam int CLK_PERIOD_NS = 4;
    localparam int READY_DELAY_CYC = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : asr_pkg

// File: asr_shadow_regs.sv
// device-side shadow register block
// Function
// - command write starts execution one clock later
// - any command-block write clears high readback
// - soft reset bit holds device busy
// - interrupt only when unmasked and selected
// - mask set forces interrupt bit in frames
// - drive/head bit 6 selects block addressing
// - drive/head bit 4 selects the drive
// - completion rewrites address bits 24-27
// - aborted flag set on command abort
// - error bits 5,3 zero, bit 7 crc
// - completion rewrites address bits 16-23
// - mid byte keeps current and previous write
// - low byte keeps current and previous write
// - zero count means 256 or 65536
// - count reads zero on success, else remaining
// - status read acknowledges pending interrupt
// - while busy every read returns status
// - ready low until device accepts commands
// - fault flag set, cleared by status read when not busy
// - seek done semantics around seeks and errors
// - transfer request flag when data ready
`timescale 1ns/1ps
module asr_shadow_regs (
    input wire logic CLK,
    input wire logic SOFT_RESET_BIT,
    input wire logic CE,
    input wire logic [3:0] REG_SEL,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic CMD_START,
    output logic [7:0] CMD_CODE,
    output logic [15:0] CMD_FEATURES,
    output logic [47:0] CMD_ADDR,
    output logic [16:0] CMD_COUNT,
    output logic CMD_LBA_MODE,
    output logic CMD_DRIVE_SEL,
    output logic SOFT_RESET,
    input wire logic DRIVE_ID,
    input wire logic DONE,
    input wire logic DONE_ERR,
    input wire logic [47:0] DONE_ADDR,
    input wire logic [15:0] DONE_REMAIN,
    input wire logic ABORT_EV,
    input wire logic CRC_EV,
    input wire logic UNC_EV,
    input wire logic IDNF_EV,
    input wire logic TK0_EV,
    input wire logic AMNF_EV,
    input wire logic FAULT_EV,
    input wire logic SEEK_START,
    input wire logic SEEK_DONE,
    input wire logic LOW_POWER,
    input wire logic XFER_READY,
    input wire logic XFER_DONE,
    input wire logic INDEX_PULSE,
    output logic INTRQ,
    output logic FRAME_IRQ_BIT
);
    logic [7:0] ctl_reg;
    logic [7:0] dh_reg;
    logic [7:0] cmd_reg;
    logic [7:0] feat_reg, feat_prev_reg;
    logic [7:0] cnt_reg, cnt_prev_reg;
    logic [7:0] lo_reg, lo_prev_reg;
    logic [7:0] mid_reg, mid_prev_reg;
    logic [7:0] hi_reg, hi_prev_reg;
    logic [7:0] err_reg;
    logic busy_reg, ready_reg, fault_reg, seek_reg, xfer_req_reg, errflag_reg;
    logic seek_hold_reg;
    logic pend_reg;
    logic start_reg;
    logic [15:0] rdy_cnt_reg;
    logic [7:0] status_w;
    logic [7:0] rdata_next;
    logic wr_ok;
    logic st_rd;
    logic drive_selected;

    function automatic logic is_cmd_block(input logic [3:0] sel);
        is_cmd_block = (sel != asr_pkg::SEL_CONTROL);
    endfunction : is_cmd_block

    // busy blocks writes other than device control
    assign wr_ok = CE && REG_WR && (!busy_reg || REG_SEL == asr_pkg::SEL_CONTROL);
    assign st_rd = CE && REG_RD && REG_SEL == asr_pkg::SEL_STATUS_CMD;
    // drive select decides ownership
    assign drive_selected = (dh_reg[asr_pkg::DH_DRIVE_SELECT_BIT] == DRIVE_ID);

    // device control and high readback
    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT) begin
            ctl_reg <= asr_pkg::RST_CONTROL;
        end else if (CE) begin
            if (wr_ok && REG_SEL == asr_pkg::SEL_CONTROL) begin
                ctl_reg <= REG_WDATA & 8'h86;
            end else if (wr_ok && is_cmd_block(REG_SEL)) begin
                ctl_reg[asr_pkg::CTL_READBACK_BIT] <= 1'b0;
            end
        end
    end

    assign SOFT_RESET = ctl_reg[asr_pkg::CTL_SOFT_RESET_BIT];

    // address, count, feature shadows with previous content
    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT || (CE && SOFT_RESET)) begin
            dh_reg <= asr_pkg::RST_DRIVE_HEAD;
            feat_reg <= asr_pkg::RST_BYTE;
            feat_prev_reg <= asr_pkg::RST_BYTE;
            cnt_reg <= asr_pkg::RST_COUNT;
            cnt_prev_reg <= asr_pkg::RST_BYTE;
            lo_reg <= asr_pkg::RST_COUNT;
            lo_prev_reg <= asr_pkg::RST_BYTE;
            mid_reg <= asr_pkg::RST_BYTE;
            mid_prev_reg <= asr_pkg::RST_BYTE;
            hi_reg <= asr_pkg::RST_BYTE;
            hi_prev_reg <= asr_pkg::RST_BYTE;
            cmd_reg <= asr_pkg::RST_BYTE;
        end else if (CE) begin
            if (DONE) begin
                dh_reg[3:0] <= DONE_ADDR[27:24];
                lo_reg <= DONE_ADDR[7:0];
                lo_prev_reg <= DONE_ADDR[31:24];
                mid_reg <= DONE_ADDR[15:8];
                mid_prev_reg <= DONE_ADDR[39:32];
                hi_reg <= DONE_ADDR[23:16];
                hi_prev_reg <= DONE_ADDR[47:40];
                // zero on success, remaining on failure
                cnt_reg <= DONE_ERR ? DONE_REMAIN[7:0] : 8'h00;
                cnt_prev_reg <= DONE_ERR ? DONE_REMAIN[15:8] : 8'h00;
            end else if (wr_ok) begin
                unique case (REG_SEL)
                    // mode and select take effect on write
                    asr_pkg::SEL_DRIVE_HEAD: dh_reg <= REG_WDATA;
                    asr_pkg::SEL_ERR_FEAT: begin
                        feat_prev_reg <= feat_reg;
                        feat_reg <= REG_WDATA;
                    end
                    asr_pkg::SEL_COUNT: begin
                        cnt_prev_reg <= cnt_reg;
                        cnt_reg <= REG_WDATA;
                    end
                    asr_pkg::SEL_ADDR_LOW: begin
                        lo_prev_reg <= lo_reg;
                        lo_reg <= REG_WDATA;
                    end
                    asr_pkg::SEL_ADDR_MID: begin
                        mid_prev_reg <= mid_reg;
                        mid_reg <= REG_WDATA;
                    end
                    asr_pkg::SEL_ADDR_HIGH: begin
                        hi_prev_reg <= hi_reg;
                        hi_reg <= REG_WDATA;
                    end
                    asr_pkg::SEL_STATUS_CMD: cmd_reg <= REG_WDATA;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT) begin
            start_reg <= 1'b0;
        end else if (CE) begin
            start_reg <= wr_ok && REG_SEL == asr_pkg::SEL_STATUS_CMD && !SOFT_RESET;
        end
    end
    assign CMD_START = start_reg;
    assign CMD_CODE = cmd_reg;
    assign CMD_FEATURES = {feat_prev_reg, feat_reg};
    assign CMD_ADDR = {hi_prev_reg, mid_prev_reg, lo_prev_reg, hi_reg, mid_reg, lo_reg};
    assign CMD_LBA_MODE = dh_reg[asr_pkg::DH_LBA_MODE_BIT];
    assign CMD_DRIVE_SEL = dh_reg[asr_pkg::DH_DRIVE_SELECT_BIT];

    // zero count expansion, 48-bit when high readback set
    always_comb begin
        if (ctl_reg[asr_pkg::CTL_READBACK_BIT] || {cnt_prev_reg, cnt_reg} != 16'h0000) begin
            if ({cnt_prev_reg, cnt_reg} == 16'h0000) begin
                CMD_COUNT = asr_pkg::ZERO_COUNT_48;
            end else begin
                CMD_COUNT = {1'b0, cnt_prev_reg, cnt_reg};
            end
        end else begin
            CMD_COUNT = asr_pkg::ZERO_COUNT_28;
        end
    end

    // error flags, cleared on a new command
    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT || (CE && SOFT_RESET)) begin
            err_reg <= 8'h00;
        end else if (CE) begin
            // an event in the start cycle wins over the clear
            if (start_reg) begin
                err_reg <= 8'h00;
            end
            if (CRC_EV) err_reg[asr_pkg::ER_LINK_CRC] <= 1'b1;
            if (UNC_EV) err_reg[asr_pkg::ER_UNCORR] <= 1'b1;
            if (IDNF_EV) err_reg[asr_pkg::ER_ID_MISS] <= 1'b1;
            if (ABORT_EV) err_reg[asr_pkg::ER_ABORTED] <= 1'b1;
            if (TK0_EV) err_reg[asr_pkg::ER_TRACK0] <= 1'b1;
            if (AMNF_EV) err_reg[asr_pkg::ER_MARK_MISS] <= 1'b1;
        end
    end

    // busy, ready, error summary
    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT) begin
            busy_reg <= 1'b1;
            ready_reg <= 1'b0;
            errflag_reg <= 1'b0;
            rdy_cnt_reg <= 16'h0000;
        end else if (CE) begin
            if (SOFT_RESET) begin
                busy_reg <= 1'b1;
                ready_reg <= 1'b0;
                rdy_cnt_reg <= 16'h0000;
            end else if (!ready_reg) begin
                if (rdy_cnt_reg == 16'(asr_pkg::READY_DELAY_CYC - 1)) begin
                    ready_reg <= 1'b1;
                    busy_reg <= 1'b0;
                end else begin
                    rdy_cnt_reg <= rdy_cnt_reg + 16'h0001;
                end
            end else if (start_reg) begin
                busy_reg <= 1'b1;
                errflag_reg <= 1'b0;
            end else if (DONE) begin
                busy_reg <= 1'b0;
                errflag_reg <= DONE_ERR;
            end else if (XFER_READY) begin
                busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT || (CE && SOFT_RESET)) begin
            xfer_req_reg <= 1'b0;
        end else if (CE) begin
            if (XFER_READY) begin
                xfer_req_reg <= 1'b1;
            end else if (XFER_DONE || DONE) begin
                xfer_req_reg <= 1'b0;
            end
        end
    end

    // fault set wins over status read clear
    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT) begin
            fault_reg <= 1'b0;
        end else if (CE) begin
            if (FAULT_EV) begin
                fault_reg <= 1'b1;
            end else if (st_rd && !busy_reg) begin
                fault_reg <= 1'b0;
            end
        end
    end

    // seek done with hold after error
    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT) begin
            seek_reg <= 1'b1;
            seek_hold_reg <= 1'b0;
        end else if (CE) begin
            if (LOW_POWER) begin
                seek_reg <= 1'b1;
                seek_hold_reg <= 1'b0;
            end else if (DONE && DONE_ERR) begin
                seek_hold_reg <= 1'b1;
            end else if (st_rd && seek_hold_reg) begin
                seek_hold_reg <= 1'b0;
            end else if (!seek_hold_reg) begin
                if (SEEK_START) begin
                    seek_reg <= 1'b0;
                end else if (SEEK_DONE) begin
                    seek_reg <= 1'b1;
                end
            end
        end
    end

    assign status_w = {busy_reg, ready_reg, fault_reg, seek_reg, xfer_req_reg, 1'b0, INDEX_PULSE, errflag_reg};

    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT || (CE && SOFT_RESET)) begin
            pend_reg <= 1'b0;
        end else if (CE) begin
            if (DONE || XFER_READY) begin
                pend_reg <= 1'b1;
            end else if (st_rd) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // interrupt gated by mask and selection
    assign INTRQ = pend_reg && !ctl_reg[asr_pkg::CTL_IRQ_MASK_BIT] && drive_selected;
    // frame interrupt bit forced while masked
    assign FRAME_IRQ_BIT = pend_reg || ctl_reg[asr_pkg::CTL_IRQ_MASK_BIT];

    // read mux
    always_comb begin
        rdata_next = 8'h00;
        if (busy_reg) begin
            rdata_next = status_w;
        end else begin
            unique case (REG_SEL)
                asr_pkg::SEL_ERR_FEAT: rdata_next = err_reg & 8'hd7;
                asr_pkg::SEL_COUNT: rdata_next = ctl_reg[asr_pkg::CTL_READBACK_BIT] ? cnt_prev_reg : cnt_reg;
                asr_pkg::SEL_ADDR_LOW: rdata_next = ctl_reg[asr_pkg::CTL_READBACK_BIT] ? lo_prev_reg : lo_reg;
                asr_pkg::SEL_ADDR_MID: rdata_next = ctl_reg[asr_pkg::CTL_READBACK_BIT] ? mid_prev_reg : mid_reg;
                asr_pkg::SEL_ADDR_HIGH: rdata_next = ctl_reg[asr_pkg::CTL_READBACK_BIT] ? hi_prev_reg : hi_reg;
                asr_pkg::SEL_DRIVE_HEAD: rdata_next = dh_reg & 8'h5f;
                asr_pkg::SEL_STATUS_CMD: rdata_next = status_w;
                asr_pkg::SEL_CONTROL: rdata_next = status_w;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SOFT_RESET_BIT) begin
            REG_RDATA <= 8'h00;
        end else if (CE && REG_RD) begin
            REG_RDATA <= rdata_next;
        end
    end

    // a_cmd_start guards command launch
    a_cmd_start: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        (CE && REG_WR && REG_SEL == asr_pkg::SEL_STATUS_CMD && !busy_reg && !SOFT_RESET) |=> CMD_START)
        else $error("command write did not start");
    a_hob_clear: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        (wr_ok && REG_SEL != asr_pkg::SEL_CONTROL) |=> !ctl_reg[asr_pkg::CTL_READBACK_BIT])
        else $error("readback bit not cleared");
    a_soft_busy: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        (CE && SOFT_RESET) |=> busy_reg)
        else $error("soft reset without busy");
    a_irq_gate: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        INTRQ |-> (!ctl_reg[asr_pkg::CTL_IRQ_MASK_BIT] && CMD_DRIVE_SEL == DRIVE_ID))
        else $error("interrupt while masked or unselected");
    a_frame_irq: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        ctl_reg[asr_pkg::CTL_IRQ_MASK_BIT] |-> FRAME_IRQ_BIT)
        else $error("frame interrupt bit not forced");
    a_count_ok: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        (CE && DONE && !DONE_ERR && !SOFT_RESET) |=> (cnt_reg == 8'h00 && cnt_prev_reg == 8'h00))
        else $error("count not zero after success");
    a_irq_ack: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        (st_rd && !DONE && !XFER_READY) |=> !pend_reg)
        else $error("status read did not acknowledge");
    a_busy_read: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        (CE && REG_RD && busy_reg) |=> REG_RDATA == $past(status_w))
        else $error("busy read not status");
    a_ready_low: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        $rose(ready_reg) |-> $past(rdy_cnt_reg) == 16'(asr_pkg::READY_DELAY_CYC - 1))
        else $error("ready raised early");
    a_fault_set: assert property (@(posedge CLK) disable iff (SOFT_RESET_BIT)
        (CE && FAULT_EV) |=> fault_reg)
        else $error("fault lost");
    c_cmd: cover property (@(posedge CLK) CMD_START ##[1:50] DONE);
    c_irq: cover property (@(posedge CLK) INTRQ ##[1:20] st_rd);
    c_soft: cover property (@(posedge CLK) $fell(SOFT_RESET) ##[1:200] ready_reg);
endmodule : asr_shadow_regs

// File: asr_host_model.sv
// host controller model issuing register accesses
`timescale 1ns/1ps
module asr_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic ce,
    output logic [3:0] sel,
    output logic wr,
    output logic rd,
    output logic [7:0] wdata
);
    int gap = 0;
    initial begin
        ce = 1'b1;
        sel = 4'h0;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end
    task automatic wr_reg(input logic [3:0] s, input logic [7:0] d);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        sel = s;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        // released data no longer shows the value
        wdata = ~d;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] s, output logic [7:0] d);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        sel = s;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    // write offered while the clock enable is low must be lost
    task automatic wr_frozen(input logic [3:0] s, input logic [7:0] d);
        @(negedge clk);
        ce = 1'b0;
        sel = s;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        ce = 1'b1;
        wdata = ~d;
    endtask : wr_frozen
    task automatic wait_idle(output logic ok);
        logic [7:0] st;
        ok = 1'b0;
        for (int i = 0; i < 200 && ok !== 1'b1; i++) begin
            rd_reg(asr_pkg::SEL_STATUS_CMD, st);
            ok = ~st[asr_pkg::ST_BUSY] & ~st[asr_pkg::ST_XFER_REQ];
        end
    endtask : wait_idle
endmodule : asr_host_model

// File: tb.sv
// self-checking bench for the shadow register block
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [3:0] ws;
        logic [7:0] wd;
        logic [3:0] rs;
        logic [7:0] m;
        logic [7:0] e;
    } asr_row_t;
    logic clk, soft_reset_bit, ce, wr, rd, ok;
    logic drive_id = 1'b0;
    logic done_err = 1'b0;
    logic low_power = 1'b0;
    logic index_pulse = 1'b0;
    logic [3:0] sel;
    logic [7:0] wdata, rdata, cmd_code;
    logic [11:0] ev = 12'h000;
    logic [15:0] cmd_features;
    logic [15:0] done_remain = 16'h0000;
    logic [47:0] cmd_addr;
    logic [47:0] done_addr = 48'h00000c5a6b7d;
    logic [16:0] cmd_count;
    logic cmd_start, cmd_lba, cmd_drive, soft_reset, intrq, frame_irq;
    int error_cnt = 0;
    int n_compared = 0;
    int n_start = 0;
    asr_row_t rows [8] = '{
        '{asr_pkg::SEL_COUNT, 8'h12, asr_pkg::SEL_COUNT, 8'hff, 8'h12},
        '{asr_pkg::SEL_ADDR_LOW, 8'h34, asr_pkg::SEL_ADDR_LOW, 8'hff, 8'h34},
        '{asr_pkg::SEL_ADDR_MID, 8'h56, asr_pkg::SEL_ADDR_MID, 8'hff, 8'h56},
        '{asr_pkg::SEL_ADDR_HIGH, 8'h78, asr_pkg::SEL_ADDR_HIGH, 8'hff, 8'h78},
        '{asr_pkg::SEL_DRIVE_HEAD, 8'h5a, asr_pkg::SEL_DRIVE_HEAD, 8'h5f, 8'h5a},
        '{asr_pkg::SEL_ERR_FEAT, 8'h9c, asr_pkg::SEL_ERR_FEAT, 8'h28, 8'h00},
        '{asr_pkg::SEL_ERR_FEAT, 8'h9c, asr_pkg::SEL_DATA, 8'hff, 8'h00},
        '{asr_pkg::SEL_ERR_FEAT, 8'h9c, asr_pkg::SEL_STATUS_CMD, 8'h04, 8'h00}};

    asr_host_model host_u (.clk(clk), .rdata(rdata), .ce(ce), .sel(sel), .wr(wr), .rd(rd), .wdata(wdata));
    asr_shadow_regs dut_u (
        .CLK(clk), .SOFT_RESET_BIT(soft_reset_bit), .CE(ce), .REG_SEL(sel), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .CMD_START(cmd_start), .CMD_CODE(cmd_code), .CMD_FEATURES(cmd_features),
        .CMD_ADDR(cmd_addr), .CMD_COUNT(cmd_count), .CMD_LBA_MODE(cmd_lba), .CMD_DRIVE_SEL(cmd_drive),
        .SOFT_RESET(soft_reset), .DRIVE_ID(drive_id), .DONE(ev[0]), .DONE_ERR(done_err), .DONE_ADDR(done_addr),
        .DONE_REMAIN(done_remain), .ABORT_EV(ev[1]), .CRC_EV(ev[2]), .UNC_EV(ev[3]), .IDNF_EV(ev[4]),
        .TK0_EV(ev[5]), .AMNF_EV(ev[6]), .FAULT_EV(ev[7]), .SEEK_START(ev[8]), .SEEK_DONE(ev[9]),
        .LOW_POWER(low_power), .XFER_READY(ev[10]), .XFER_DONE(ev[11]), .INDEX_PULSE(index_pulse),
        .INTRQ(intrq), .FRAME_IRQ_BIT(frame_irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cmd_start === 1'b1) begin
            n_start++;
        end
    end

    task final_report();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task w(input logic [3:0] s, input logic [7:0] d);
        host_u.wr_reg(s, d);
    endtask : w
    task rchk(input logic [3:0] s, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        host_u.rd_reg(s, v);
        chk(v & m, e);
    endtask : rchk
    task cmd(input logic [7:0] code);
        w(asr_pkg::SEL_STATUS_CMD, code);
        repeat (2) @(negedge clk);
    endtask : cmd
    task pulse(input logic [11:0] m);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 12'h000;
    endtask : pulse
    task ready();
        host_u.wait_idle(ok);
        chk(ok, 1'b1);
        if (ok !== 1'b1) begin
            final_report();
        end
    endtask : ready

    initial begin
        soft_reset_bit = 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        soft_reset_bit = 1'b0;
        rchk(asr_pkg::SEL_STATUS_CMD, 8'hc0, 8'h80);
        ready();
        rchk(asr_pkg::SEL_STATUS_CMD, 8'hc4, 8'h40);
        foreach (rows[i]) begin
            w(rows[i].ws, rows[i].wd);
            rchk(rows[i].rs, rows[i].m, rows[i].e);
        end
        chk({cmd_lba, cmd_drive}, 2'b11);
        // two-deep address and count bytes
        w(asr_pkg::SEL_ADDR_LOW, 8'h11);
        w(asr_pkg::SEL_ADDR_LOW, 8'h22);
        w(asr_pkg::SEL_ADDR_MID, 8'h33);
        w(asr_pkg::SEL_ADDR_MID, 8'h44);
        w(asr_pkg::SEL_ADDR_HIGH, 8'h55);
        w(asr_pkg::SEL_ADDR_HIGH, 8'h66);
        w(asr_pkg::SEL_COUNT, 8'h00);
        w(asr_pkg::SEL_COUNT, 8'h00);
        chk(cmd_addr, 48'h553311664422);
        chk(cmd_count, 17'h00100);
        w(asr_pkg::SEL_CONTROL, 8'h80);
        chk(cmd_count, 17'h10000);
        rchk(asr_pkg::SEL_ADDR_LOW, 8'hff, 8'h11);
        w(asr_pkg::SEL_ERR_FEAT, 8'h00);
        rchk(asr_pkg::SEL_ADDR_LOW, 8'hff, 8'h22);
        chk(cmd_features, 16'h9c00);
        // successful command, unmasked and selected
        w(asr_pkg::SEL_CONTROL, 8'h00);
        w(asr_pkg::SEL_DRIVE_HEAD, 8'h40);
        w(asr_pkg::SEL_COUNT, 8'h03);
        cmd(8'h25);
        chk({n_start[7:0], cmd_code}, 16'h0125);
        chk({cmd_lba, cmd_drive}, 2'b10);
        rchk(asr_pkg::SEL_COUNT, 8'h80, 8'h80);
        pulse(12'h400);
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h88, 8'h08);
        pulse(12'h800);
        pulse(12'h001);
        chk(intrq, 1'b1);
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h89, 8'h00);
        chk(intrq, 1'b0);
        rchk(asr_pkg::SEL_ADDR_HIGH, 8'hff, 8'h5a);
        host_u.wr_frozen(asr_pkg::SEL_ADDR_HIGH, 8'h99);
        rchk(asr_pkg::SEL_ADDR_HIGH, 8'hff, 8'h5a);
        rchk(asr_pkg::SEL_DRIVE_HEAD, 8'h5f, 8'h4c);
        rchk(asr_pkg::SEL_COUNT, 8'hff, 8'h00);
        // failing command with every error event, masked
        w(asr_pkg::SEL_CONTROL, 8'h02);
        w(asr_pkg::SEL_COUNT, 8'h09);
        cmd(8'h24);
        chk(n_start, 2);
        pulse(12'h07e);
        done_err = 1'b1;
        done_remain = 16'h0007;
        pulse(12'h001);
        chk({intrq, frame_irq}, 2'b01);
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h81, 8'h01);
        rchk(asr_pkg::SEL_ERR_FEAT, 8'hff, 8'hd7);
        rchk(asr_pkg::SEL_COUNT, 8'hff, 8'h07);
        done_err = 1'b0;
        // other drive selected, slow host
        host_u.gap = 3;
        w(asr_pkg::SEL_CONTROL, 8'h00);
        w(asr_pkg::SEL_DRIVE_HEAD, 8'h50);
        cmd(8'h20);
        chk(n_start, 3);
        pulse(12'h001);
        chk({intrq, frame_irq}, 2'b01);
        ready();
        host_u.gap = 0;
        pulse(12'h080);
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h20, 8'h20);
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h20, 8'h00);
        pulse(12'h100);
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h10, 8'h00);
        low_power = 1'b1;
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h10, 8'h10);
        low_power = 1'b0;
        pulse(12'h100);
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h10, 8'h00);
        pulse(12'h200);
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h10, 8'h10);
        index_pulse = 1'b1;
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h02, 8'h02);
        index_pulse = 1'b0;
        // soft reset holds the device busy
        w(asr_pkg::SEL_CONTROL, 8'h04);
        chk(soft_reset, 1'b1);
        rchk(asr_pkg::SEL_STATUS_CMD, 8'h80, 8'h80);
        cmd(8'h20);
        chk(n_start, 3);
        w(asr_pkg::SEL_CONTROL, 8'h00);
        chk(soft_reset, 1'b0);
        ready();
        rchk(asr_pkg::SEL_STATUS_CMD, 8'hc0, 8'h40);
        final_report();
    end
endmodule : tb
